// ===== common/serial_rx_consts.vh
// constants for the serial receive and error-flag block
// assumes a 32-bit register port with word-aligned byte addresses
`ifndef SERIAL_RX_CONSTS_VH
`define SERIAL_RX_CONSTS_VH
// register byte addresses
`define A_STATUS 8'h00
`define A_RXBUF 8'h04
`define A_MODE0 8'h08
`define A_MODE2 8'h0c
`define A_FIFO 8'h10
`define A_CLK 8'h14
// serial_control_status fields
`define CS_OVR 0
`define CS_PUR 1
`define CS_FRM 2
`define CS_RB8 4
`define CS_CLKDIR 5
`define CS_EDGE 6
// mode_control_zero fields
`define M0_RXE 0
`define M0_UART 1
`define M0_NINE 2
`define M0_PAR 3
`define M0_ODD 4
`define M0_WU 5
// mode_control_two fields
`define M2_DBUF 0
`define M2_FULL 1
// fifo_config fields
`define FC_EN 0
`define FC_AUTO 1
`define FC_DPX 2
`define FC_RFIS 3
`define FC_LVL_LO 4
`define FC_LVL_HI 6
// reset values
`define RST_M0 6'h00
`define RST_DIV 8'h00
`define RST_LVL 3'h1
// receive counter and frame figures
`define CNT_S1 4'h7
`define CNT_S2 4'h8
`define CNT_S3 4'h9
`define BIT_LAST8 4'h7
`define BIT_LAST9 4'h8
`define FIFO_FULL_CAP 3'h4
`define FIFO_DUP_CAP 3'h2
`endif

// ===== core/serial_rx.v
// receive path and error flags of a uart / clocked shift port
// assumes a register port on i_clk_sys and pins synced here
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "serial_rx_consts.vh"
module serial_rx (
    // clock and reset
    input wire i_clk_sys,
    input wire i_reset,
    // register port
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    // serial pins
    input wire i_rxd,
    input wire i_sclk,
    output wire o_sclk,
    output wire o_sclk_oe,
    // transmit side status and receive interrupt
    input wire i_tx_empty,
    output reg o_rx_irq
);
    localparam U_IDLE = 2'h0;
    localparam U_START = 2'h1;
    localparam U_DATA = 2'h2;
    localparam U_STOP = 2'h3;

    // majority of three samples
    function maj3;
        input a, b, c;
        begin
            maj3 = (a & b) | (a & c) | (b & c);
        end
    endfunction

    integer i;
    reg [5:0] mode0_q;
    reg dbuf_q;
    reg [6:0] fcfg_q;
    reg clkdir_q, edge_q;
    reg [7:0] div_q, dcnt_q;
    reg ovr_q, pur_q, frm_q;
    reg [2:0] rxd_s, sclk_s;
    reg sclk_q, halt_q;
    reg [1:0] ust_q;
    reg [3:0] cnt_q, idx_q;
    reg smp1_q, smp2_q;
    reg [8:0] sh_q, buf_q;
    reg buf_v_q, shf_q;
    reg [7:0] fifo_q [0:3];
    reg [2:0] fcnt_q;

    // configuration decode
    wire rxe = mode0_q[`M0_RXE];
    wire uart = mode0_q[`M0_UART];
    wire nine = mode0_q[`M0_NINE];
    wire par_en = mode0_q[`M0_PAR];
    wire fifo_en = fcfg_q[`FC_EN] & dbuf_q;
    wire auto_dis = fcfg_q[`FC_AUTO];
    wire [2:0] lvl = fcfg_q[`FC_LVL_HI:`FC_LVL_LO];
    wire int_clk = ~uart & ~clkdir_q;
    wire ext_clk = ~uart & clkdir_q;
    wire dbl = uart | clkdir_q | dbuf_q;
    wire [2:0] cap = fcfg_q[`FC_DPX] ? `FIFO_DUP_CAP
                                     : `FIFO_FULL_CAP;
    wire [3:0] last = (nine | par_en) ? `BIT_LAST9 : `BIT_LAST8;

    // serial base clock tick from the system clock
    wire tick = (dcnt_q == div_q);
    always @(posedge i_clk_sys) begin
        if (i_reset || tick)
            dcnt_q <= 8'h00;
        else
            dcnt_q <= dcnt_q + 8'h01;
    end

    // two-flop synchronisers, third stage for edge finding
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            rxd_s <= 3'h7;
            sclk_s <= 3'h7;
        end else begin
            rxd_s <= {rxd_s[1:0], i_rxd};
            sclk_s <= {sclk_s[1:0], i_sclk};
        end
    end
    wire rxd = rxd_s[1];
    wire sclk_rise = sclk_s[1] & ~sclk_s[2];
    wire sclk_fall = ~sclk_s[1] & sclk_s[2];

    // internal shift clock: runs while enabled and not halted
    wire run = int_clk & rxe & ~halt_q;
    wire own_rise = run & tick & ~sclk_q;
    assign o_sclk = sclk_q;
    assign o_sclk_oe = int_clk;
    always @(posedge i_clk_sys) begin
        if (i_reset)
            sclk_q <= 1'b1;
        else if (run && tick)
            sclk_q <= ~sclk_q;
        else if (!run)
            sclk_q <= 1'b1;
    end

    // clocked-mode sample strobe
    wire smp_io = rxe & (int_clk ? own_rise
                 : ext_clk & (edge_q ? sclk_fall : sclk_rise));

    // uart sampling: bit decided at count nine by majority
    wire maj = maj3(smp1_q, smp2_q, rxd);
    wire dec = uart & rxe & tick & (cnt_q == `CNT_S3) &
               (ust_q != U_IDLE);
    wire u_done = dec & (ust_q == U_STOP);
    wire io_done = smp_io & (idx_q == `BIT_LAST8);
    wire done = u_done | io_done;
    wire [8:0] done_data = uart ? sh_q : {1'b0, rxd, sh_q[6:0]};

    // receive control: counter, start detect, shift register
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            ust_q <= U_IDLE;
            cnt_q <= 4'h0;
            idx_q <= 4'h0;
            sh_q <= 9'h000;
            smp1_q <= 1'b1;
            smp2_q <= 1'b1;
        end else if (!rxe) begin
            ust_q <= U_IDLE;
            idx_q <= 4'h0;
        end else if (!uart) begin
            ust_q <= U_IDLE;
            if (smp_io) begin
                sh_q[idx_q[2:0]] <= rxd;
                idx_q <= io_done ? 4'h0 : idx_q + 4'h1;
            end
        end else if (tick) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `CNT_S1)
                smp1_q <= rxd;
            if (cnt_q == `CNT_S2)
                smp2_q <= rxd;
            case (ust_q)
                U_IDLE: begin
                    cnt_q <= 4'h1;
                    idx_q <= 4'h0;
                    if (!rxd)
                        ust_q <= U_START;
                end
                U_START: begin
                    if (dec)
                        ust_q <= maj ? U_IDLE : U_DATA;
                end
                U_DATA: begin
                    if (dec) begin
                        sh_q[idx_q] <= maj;
                        idx_q <= idx_q + 4'h1;
                        if (idx_q == last)
                            ust_q <= U_STOP;
                    end
                end
                U_STOP: begin
                    if (dec)
                        ust_q <= U_IDLE; // one stop bit only
                end
                default: ust_q <= U_IDLE;
            endcase
        end
    end

    // buffer, fifo movement and read effects
    wire rd_cs = i_rd & (i_addr == `A_STATUS);
    wire rd_buf = i_rd & (i_addr == `A_RXBUF);
    wire pop = rd_buf & fifo_en & (fcnt_q != 3'h0);
    wire clr_rd = rd_buf & ~pop & buf_v_q;
    wire move = fifo_en & buf_v_q & ~clr_rd &
                ((fcnt_q < cap) | pop);
    wire frees = clr_rd | move;
    wire room = ~buf_v_q | frees;
    wire lost = done & ~room & ~int_clk;
    wire hold = done & ~room & int_clk;
    wire [2:0] wr_idx = fcnt_q - {2'b00, pop};
    wire [2:0] fcnt_d = fcnt_q + {2'b00, move} - {2'b00, pop};
    wire all_full = done & ~room & fifo_en & (fcnt_q == cap);

    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            buf_q <= 9'h000;
            buf_v_q <= 1'b0;
            shf_q <= 1'b0;
            fcnt_q <= 3'h0;
        end else begin
            if (done && room) begin
                buf_q <= done_data;
                buf_v_q <= 1'b1;
            end else if (shf_q && room) begin
                buf_q <= sh_q;
                buf_v_q <= 1'b1;
                shf_q <= 1'b0;
            end else if (frees) begin
                buf_v_q <= 1'b0;
            end
            if (hold)
                shf_q <= 1'b1;
            if (!dbl)
                shf_q <= 1'b0;
            fcnt_q <= fcnt_d;
        end
    end

    // fifo storage: head at entry zero, shifts on pop
    always @(posedge i_clk_sys) begin
        for (i = 0; i < 4; i = i + 1) begin
            if (pop && i < 3)
                fifo_q[i] <= fifo_q[i + 1];
            if (move && i == wr_idx)
                fifo_q[i] <= buf_q[7:0];
        end
    end

    // clock halt for internal clock mode
    wire halt_d = int_clk & (dbl ? (shf_q | hold) : (buf_v_q & ~frees)
                  | (done & ~dbl)) | (int_clk & ovr_q);
    wire halt_rise = halt_d & ~halt_q & rxe;
    always @(posedge i_clk_sys) begin
        if (i_reset)
            halt_q <= 1'b0;
        else
            halt_q <= halt_d;
    end

    // error events
    wire par_bad = u_done & par_en & ~nine &
                   ((^sh_q) != mode0_q[`M0_ODD]);
    wire und_ext = ext_clk & dbl & smp_io &
                   (idx_q == 4'h0) & i_tx_empty;
    wire und_int = int_clk & dbl & halt_rise & i_tx_empty;
    wire frm_bad = u_done & ~rxd & ~smp1_q & ~smp2_q |
                   u_done & ~maj;

    // error flags: set wins over the read clear
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            ovr_q <= 1'b0;
            pur_q <= 1'b0;
            frm_q <= 1'b0;
        end else begin
            ovr_q <= lost | (ovr_q & ~rd_cs);
            pur_q <= par_bad | und_ext | und_int |
                     (pur_q & ~rd_cs);
            frm_q <= uart & (frm_bad | (frm_q & ~rd_cs));
        end
    end

    // receive interrupt
    wire wake_ok = ~(uart & nine & mode0_q[`M0_WU]) |
                   done_data[8];
    wire lvl_ok = fcfg_q[`FC_RFIS] ? (fcnt_d >= lvl) : (fcnt_d == lvl);
    always @(posedge i_clk_sys) begin
        if (i_reset)
            o_rx_irq <= 1'b0;
        else if (fifo_en)
            o_rx_irq <= (done | pop) & lvl_ok;
        else
            o_rx_irq <= done & ~lost & wake_ok;
    end

    // configuration registers and enable auto clear
    wire rxe_clr = (fifo_en & all_full) |
                   (auto_dis & halt_rise);
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            mode0_q <= `RST_M0;
            dbuf_q <= 1'b0;
            fcfg_q <= {`RST_LVL, 4'h0};
            clkdir_q <= 1'b0;
            edge_q <= 1'b0;
            div_q <= `RST_DIV;
        end else begin
            if (i_wr && i_addr == `A_MODE0)
                mode0_q <= i_wdata[5:0];
            if (i_wr && i_addr == `A_MODE2)
                dbuf_q <= i_wdata[`M2_DBUF];
            if (i_wr && i_addr == `A_FIFO)
                fcfg_q <= i_wdata[6:0];
            if (i_wr && i_addr == `A_STATUS) begin
                clkdir_q <= i_wdata[`CS_CLKDIR];
                edge_q <= i_wdata[`CS_EDGE];
            end
            if (i_wr && i_addr == `A_CLK)
                div_q <= i_wdata[7:0];
            if (rxe_clr)
                mode0_q[`M0_RXE] <= 1'b0;
        end
    end

    // read data, valid only in the cycle after the strobe
    always @(posedge i_clk_sys) begin
        if (i_reset || !i_rd) begin
            o_rdata <= 32'h00000000;
        end else begin
            case (i_addr)
                `A_STATUS: o_rdata <= {25'h0000000, edge_q, clkdir_q,
                                       buf_q[8], 1'b0, frm_q, pur_q,
                                       ovr_q};
                `A_RXBUF: o_rdata <= {24'h000000, (fifo_en &&
                             fcnt_q != 3'h0) ? fifo_q[0] : buf_q[7:0]};
                `A_MODE0: o_rdata <= {26'h0000000, mode0_q};
                `A_MODE2: o_rdata <= {30'h00000000, buf_v_q & dbl,
                                      dbuf_q};
                `A_FIFO: o_rdata <= {22'h000000, fcnt_q, fcfg_q};
                `A_CLK: o_rdata <= {24'h000000, div_q};
                default: o_rdata <= 32'h00000000;
            endcase
        end
    end
endmodule // serial_rx
`default_nettype wire

// ===== verification/serial_rx_properties.sv
// checker for the serial receive block, bound to its ports
// assumes the register map of serial_rx_consts.vh
`timescale 1ns/1ps
`default_nettype none
`include "serial_rx_consts.vh"
module serial_rx_properties (
    // clock and reset
    input wire i_clk_sys,
    input wire i_reset,
    // register port
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [31:0] o_rdata,
    // serial pins and interrupt
    input wire i_rxd,
    input wire i_sclk,
    input wire o_sclk,
    input wire o_sclk_oe,
    input wire o_rx_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    logic [6:0] quiet_q;
    logic [1:0] lines_q;
    wire rd_st = i_rd && (i_addr == `A_STATUS);
    wire [4:0] wd_mode = i_wdata[5:1];
    // cycles with the line idle and no clock edge, so no event is due
    always @(posedge i_clk_sys) begin
        lines_q <= {i_sclk, o_sclk};
        if (i_reset || !i_rxd || lines_q != {i_sclk, o_sclk})
            quiet_q <= 7'h00;
        else if (quiet_q != 7'h7f)
            quiet_q <= quiet_q + 7'h01;
    end
    property p_idle;
        !i_rd |=> o_rdata == 32'h0;
    endproperty
    a_idle: assert property (p_idle)
        else $error("read data outside answer");
    property p_irq;
        o_rx_irq |=> !o_rx_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq longer than a pulse");
    property p_ext;
        i_wr && i_addr == `A_STATUS && i_wdata[`CS_CLKDIR] |=> !o_sclk_oe;
    endproperty
    a_ext: assert property (p_ext)
        else $error("drives clock in external mode");
    property p_unmap;
        i_rd && i_addr > `A_CLK |=> o_rdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    property p_cap;
        i_rd && i_addr == `A_FIFO |=> o_rdata[9:7] <= `FIFO_FULL_CAP;
    endproperty
    a_cap: assert property (p_cap)
        else $error("fifo count above capacity");
    property p_clr;
        rd_st && quiet_q == 7'h7f ##1 rd_st |=> o_rdata[2:0] == 3'h0;
    endproperty
    a_clr: assert property (p_clr)
        else $error("flags survive status read");
    property p_rbf;
        i_rd && i_addr == `A_RXBUF && quiet_q == 7'h7f && !o_sclk_oe
            ##1 i_rd && i_addr == `A_MODE2 |=> !o_rdata[`M2_FULL];
    endproperty
    a_rbf: assert property (p_rbf)
        else $error("buffer full after read");
    property p_m0;
        i_wr && i_addr == `A_MODE0 ##1 i_rd && i_addr == `A_MODE0
            |=> o_rdata[5:1] == $past(wd_mode, 2);
    endproperty
    a_m0: assert property (p_m0)
        else $error("mode bits lost");
    c_irq: cover property (o_rx_irq);
    c_ovr: cover property (rd_st ##1 o_rdata[`CS_OVR]);
    c_frm: cover property (rd_st ##1 o_rdata[`CS_FRM]);
endmodule // serial_rx_properties
bind serial_rx serial_rx_properties chk (.i_clk_sys(i_clk_sys),
    .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd), .i_sclk(i_sclk),
    .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe), .o_rx_irq(o_rx_irq));
`default_nettype wire

// ===== verification/serial_far_end.sv
// far-end model: uart transmitter or clocked shift source
// assumes base tick every system cycle for uart timing
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
    // shift clock from the device
    input wire logic i_dev_sclk,
    // line outputs
    output var logic o_rxd,
    output var logic o_sclk
);
    logic [7:0] sh_q;
    int idx;
    initial begin
        o_rxd = 1'b1;
        o_sclk = 1'b1;
        idx = 8;
    end
    // uart frame: start, data lsb first, parity, one stop
    task send_uart(input logic [7:0] d, input logic par, input logic stp);
        logic [10:0] fr;
        fr = {stp, par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            o_rxd = fr[i];
            #640;
        end
        o_rxd = 1'b1; // mark level between frames
    endtask
    // clocked frame; link clock runs only inside it
    // data changes away from both edges, so either edge select sees it
    task send_clk(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            o_rxd = d[i];
            #80 o_sclk = 1'b0;
            #160 o_sclk = 1'b1;
            #80;
        end
        o_rxd = ~o_rxd; // released line shows no stale bit
    endtask
    task load(input logic [7:0] d);
        sh_q = d;
        idx = -1;
    endtask
    // next bit on each falling edge of the device clock
    always @(negedge i_dev_sclk) begin
        idx = idx + 1;
        o_rxd = (idx < 8) ? sh_q[idx[2:0]] : ~o_rxd;
    end
endmodule // serial_far_end
`default_nettype wire

// ===== verification/test_serial_rx.sv
// self-checking bench for the serial receive block
// assumes the far-end model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "serial_rx_consts.vh"
module test_serial_rx;
    logic i_clk_sys, i_reset, i_wr, i_rd, i_tx_empty, par;
    logic [7:0] i_addr, d, d1;
    logic [31:0] i_wdata, q;
    wire [31:0] o_rdata;
    wire o_sclk, o_sclk_oe, o_rx_irq, rxd, sclk;
    int err_count, checks_done, seed, irq_cnt, rise_cnt, n;
    serial_rx dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_rxd(rxd), .i_sclk(sclk), .o_sclk(o_sclk),
        .o_sclk_oe(o_sclk_oe), .i_tx_empty(i_tx_empty),
        .o_rx_irq(o_rx_irq));
    serial_far_end far (.i_dev_sclk(o_sclk), .o_rxd(rxd), .o_sclk(sclk));
    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    // counts interrupt pulses and device clock edges
    always @(posedge i_clk_sys) if (o_rx_irq === 1'b1) irq_cnt++;
    always @(posedge o_sclk) rise_cnt++;
    task check(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        #1;
    endtask
    // read, then compare the masked answer
    task rd(input string nm, input logic [7:0] a, input logic [31:0] m, e);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 q = o_rdata;
        check(nm, q & m, e);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        finish_test;
    end
    initial begin
        i_reset = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_tx_empty = 1'b1;
        seed = 23;
        err_count = 0;
        checks_done = 0;
        irq_cnt = 0;
        repeat (5) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        @(posedge i_clk_sys);
        rd("status", `A_STATUS, '1, 32'h0);
        rd("fifo cfg", `A_FIFO, '1, 32'h10);
        rd("unmapped", 8'h20, '1, 32'h0);
        // uart, even parity, double buffer
        wr(`A_CLK, 32'h0);
        wr(`A_MODE2, 32'h1);
        wr(`A_MODE0, 32'h0b);
        rd("mode0", `A_MODE0, '1, 32'h0b);
        for (int k = 0; k < 4; k++) begin
            d = $random(seed);
            par = (k == 1) ? ~^d : ^d;
            far.send_uart(d, par, k != 2);
            repeat (140) @(posedge i_clk_sys);
            check("irq", irq_cnt, k + 1);
            rd("buf set", `A_MODE2, '1, 32'h3);
            rd("rx data", `A_RXBUF, '1, {24'h0, d});
            rd("buf full", `A_MODE2, '1, 32'h1);
            rd("flags", `A_STATUS, 32'h17,
                {27'h0, par, 1'b0, k == 2, k == 1, 1'b0});
            rd("cleared", `A_STATUS, 32'h17, {27'h0, par, 4'h0});
        end
        // three frames unread: overrun keeps the first byte
        d1 = $random(seed);
        far.send_uart(d1, ^d1, 1'b1);
        for (int k = 0; k < 2; k++)
            far.send_uart(d1 + 8'h11, ^(d1 + 8'h11), 1'b1);
        repeat (40) @(posedge i_clk_sys);
        rd("overrun", `A_STATUS, 32'h11, {27'h0, ^d1, 4'h1});
        rd("kept", `A_RXBUF, '1, {24'h0, d1});
        rd("drain", `A_RXBUF, 32'h0, 32'h0);
        rd("drain", `A_STATUS, 32'h0, 32'h0);
        // nine-bit wake-up, fifo kept off: irq only for ninth bit one
        wr(`A_MODE0, 32'h27);
        for (int k = 0; k < 2; k++) begin
            n = irq_cnt;
            d = $random(seed);
            far.send_uart(d, k[0], 1'b1);
            repeat (40) @(posedge i_clk_sys);
            check("wake irq", irq_cnt, n + k);
            rd("wake data", `A_RXBUF, '1, {24'h0, d});
            rd("ninth bit", `A_STATUS, 32'h17, {27'h0, k[0], 4'h0});
        end
        // external link clock on both edges, underrun per tx state
        wr(`A_STATUS, 32'h20);
        wr(`A_MODE0, 32'h1);
        n = irq_cnt;
        for (int k = 0; k < 2; k++) begin
            d = $random(seed);
            i_tx_empty <= (k == 0);
            wr(`A_STATUS, k ? 32'h60 : 32'h20);
            far.send_clk(d);
            repeat (20) @(posedge i_clk_sys);
            check("irq", irq_cnt, n + k + 1);
            rd("rx data", `A_RXBUF, '1, {24'h0, d});
            rd("flags", `A_STATUS, 32'h67, k ? 32'h60 : 32'h22);
        end
        // device clock, single buffer: stops after one frame
        wr(`A_MODE0, 32'h0);
        wr(`A_STATUS, 32'h0);
        wr(`A_MODE2, 32'h0);
        wr(`A_CLK, 32'h3);
        check("drives clock", o_sclk_oe, 1'b1);
        for (int k = 0; k < 2; k++) begin
            d = $random(seed);
            far.load(d);
            rise_cnt = 0;
            if (k == 0)
                wr(`A_MODE0, 32'h1);
            else
                rd("rx data", `A_RXBUF, '1, {24'h0, d1});
            repeat (200) @(posedge i_clk_sys);
            check("clock edges", rise_cnt, 8);
            d1 = d;
        end
        rd("rx data", `A_RXBUF, '1, {24'h0, d1});
        finish_test;
    end
endmodule // test_serial_rx
`default_nettype wire
